// ===== src/seismic_channel_config_regs.sv
// Configuration register bank for a dual amplifier and modulator channel pair.
// Holds the fixed revision code, the channel one register with its decoded controls,
// and plain registers for channel two, the modulator pair and the bias currents.
// Assumes an external SPI master; all registers sit on the system clock.
// Assumes chip select stays high at least three clocks between frames, and that
// each SCK half period lasts four system clocks or more.
// Assumes the analog side takes the configuration outputs as static levels.
// Assumes reset clears the writable registers and leaves the revision code alone.
//
// Summary of operation
// - Five 8-bit registers at 0x00 to 0x04; address 0 read-only, others read/write.
// - Address 0x00 always returns the same fixed 8-bit revision code.
// - Channel one register: sleep, precision, input select, guard off, gain.
// - Channel one register resets to all zeros.
// - Bit positions without a function read back as zero.
// - Input select 11 both, 10 A only, 01 B only, 00 termination.
// - Gain is two to the power of the code, 000 to 110; 111 reserved.
// - Sleep and precision active high; guard bit active low.
`timescale 1ns/100ps
module seismic_channel_config_regs
    import config_regs_pkg::*;
#(
    // Revision code value is arbitrary.
    parameter logic [7:0] REVISION_CODE = 8'hA5
)
(
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // SPI port.
    input wire logic SPI_SCK,
    input wire logic SPI_CS_N,
    input wire logic SPI_MOSI,
    output logic SPI_MISO,
    output logic SPI_MISO_OE,
    // Configuration outputs to the analog channels.
    output channel_one_ctrl_t CH1_CTRL,
    output logic [7:0] AMP2_CONFIG,
    output logic [7:0] MODULATOR_CONFIG,
    output logic [7:0] BIAS_CONFIG
);

    ////////////////////////////////////////////////////////////////////////////
    logic [6:0] reg_addr;
    logic wr_strobe;
    logic [7:0] wr_data;
    logic [7:0] read_data;
    amp_one_cfg_t amp_one_reg;
    logic [7:0] amp_two_reg;
    logic [7:0] modulator_reg;
    logic [7:0] bias_reg;
    channel_one_ctrl_t ch1_ctrl_reg, ch1_ctrl_next;
    wire sel_amp_one;
    wire sel_amp_two;
    wire sel_modulator;
    wire sel_bias;
    wire sel_revision;
    wire [7:0] revision_code_field;

    // Per-register write enables and gated read terms.
    wire wr_amp_one;
    wire wr_amp_two;
    wire wr_modulator;
    wire wr_bias;
    wire [7:0] rd_revision;
    wire [7:0] rd_amp_one;
    wire [7:0] rd_amp_two;
    wire [7:0] rd_modulator;
    wire [7:0] rd_bias;

    // Serial port front end. Each 16-bit frame becomes one register access: the
    // command byte sets the address, and the data byte is written or shifted out.
    // A write reaches the registers a few clocks after the last SCK rise at the pin.
    // A frame whose chip select rises early writes nothing at all.
    // Read data is taken from the mux one clock after the command byte completes.
    spi_frame_port port_inst (
        .clk(CLK_SYS),
        .resetn(RESETN),
        .sck_pin(SPI_SCK),
        .cs_n_pin(SPI_CS_N),
        .mosi_pin(SPI_MOSI),
        .miso(SPI_MISO),
        .miso_oe(SPI_MISO_OE),
        .read_data(read_data),
        .reg_addr(reg_addr),
        .wr_strobe(wr_strobe),
        .wr_data(wr_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode; the revision register has no write select at all.
    // Only the low seven bits of the command byte form the address. Every address
    // above the bias register decodes to nothing, so reads return zero there and
    // writes are dropped without touching any register.
    assign sel_revision = (reg_addr == ADDR_REVISION);
    assign sel_amp_one = (reg_addr == ADDR_AMP_ONE);
    assign sel_amp_two = (reg_addr == ADDR_AMP_TWO);
    assign sel_modulator = (reg_addr == ADDR_MODULATOR);
    assign sel_bias = (reg_addr == ADDR_BIAS);
    assign revision_code_field = REVISION_CODE;

    // Write enables; address 0 and unmapped addresses never get one.
    // The port raises its strobe for one clock, so a frame loads one register once.
    assign wr_amp_one = wr_strobe && sel_amp_one;
    assign wr_amp_two = wr_strobe && sel_amp_two;
    assign wr_modulator = wr_strobe && sel_modulator;
    assign wr_bias = wr_strobe && sel_bias;

    // Channel one register; every bit holds a function, so the mask keeps all of them.
    // Its decode below lags it by one clock.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            amp_one_reg <= amp_one_cfg_t'(AMP_ONE_RESET);
        end else if (wr_amp_one) begin
            amp_one_reg <= amp_one_cfg_t'(wr_data & AMP_ONE_MASK);
        end
    end

    // Channel two register; its reserved bit is cleared on the way in.
    // It therefore always reads back as zero.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            amp_two_reg <= AMP_TWO_RESET;
        end else if (wr_amp_two) begin
            amp_two_reg <= wr_data & AMP_TWO_MASK;
        end
    end

    // Modulator register; the low nibble holds no function and stores zero.
    // Clearing on write keeps the read path a plain copy of the register.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            modulator_reg <= MODULATOR_RESET;
        end else if (wr_modulator) begin
            modulator_reg <= wr_data & MODULATOR_MASK;
        end
    end

    // Bias register; bit 6 holds no function and stores zero.
    // A stored one there could otherwise leak onto the bias output.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            bias_reg <= BIAS_RESET;
        end else if (wr_bias) begin
            bias_reg <= wr_data & BIAS_MASK;
        end
    end

    // Read mux; unmapped addresses read as zero.
    // Each source is gated by its own select; the selects are exclusive, so at most
    // one term is non-zero and a plain OR merges them. The revision code comes
    // straight from the parameter, so neither reset nor any write can alter it.
    assign rd_revision = sel_revision ? revision_code_field : 8'h00;
    assign rd_amp_one = sel_amp_one ? 8'(amp_one_reg) : 8'h00;
    assign rd_amp_two = sel_amp_two ? amp_two_reg : 8'h00;
    assign rd_modulator = sel_modulator ? modulator_reg : 8'h00;
    assign rd_bias = sel_bias ? bias_reg : 8'h00;
    assign read_data = rd_revision | rd_amp_one | rd_amp_two | rd_modulator | rd_bias;

    ////////////////////////////////////////////////////////////////////////////
    // Channel one decode into front-end controls, registered for clean outputs.
    // Exactly one path is chosen for each select code: both inputs, one input,
    // or the termination. An unused code can never leave the input floating.
    // Registering the decode keeps glitches of the select logic off the switches.
    // The reserved gain code is kept in the register so that it reads back as written.
    always_comb begin
        ch1_ctrl_next.sleep = amp_one_reg.channel_one_sleep;
        ch1_ctrl_next.precision = amp_one_reg.channel_one_precision;
        ch1_ctrl_next.guard_en = !amp_one_reg.guard_off;
        ch1_ctrl_next.input_a_en = 1'b0;
        ch1_ctrl_next.input_b_en = 1'b0;
        ch1_ctrl_next.termination_en = 1'b0;
        case (amp_one_reg.channel_one_input_select)
            SEL_BOTH: begin
                ch1_ctrl_next.input_a_en = 1'b1;
                ch1_ctrl_next.input_b_en = 1'b1;
            end
            SEL_INPUT_A: begin
                ch1_ctrl_next.input_a_en = 1'b1;
            end
            SEL_INPUT_B: begin
                ch1_ctrl_next.input_b_en = 1'b1;
            end
            SEL_TERMINATION: begin
                ch1_ctrl_next.termination_en = 1'b1;
            end
            default: begin
                ch1_ctrl_next.termination_en = 1'b1;
            end
        endcase
        // Reserved gain code falls back to unity gain and raises a flag.
        if (amp_one_reg.channel_one_amplification == GAIN_RESERVED) begin
            ch1_ctrl_next.gain_log2 = 3'h0;
            ch1_ctrl_next.gain_reserved = 1'b1;
        end else begin
            ch1_ctrl_next.gain_log2 = amp_one_reg.channel_one_amplification;
            ch1_ctrl_next.gain_reserved = 1'b0;
        end
    end

    // Output stage for the channel one controls.
    // Reset clears it to all zeros; the decode of the reset value follows one clock
    // after release, which turns the termination and the guard on.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ch1_ctrl_reg <= '0;
        end else begin
            ch1_ctrl_reg <= ch1_ctrl_next;
        end
    end

    // Remaining configuration passes straight from the registers.
    // These outputs come from flip-flops and change only on a committed write or reset.
    // The analog side may therefore hold them as static levels between frames.
    assign CH1_CTRL = ch1_ctrl_reg;
    assign AMP2_CONFIG = amp_two_reg;
    assign MODULATOR_CONFIG = modulator_reg;
    assign BIAS_CONFIG = bias_reg;

endmodule

// ===== src/config_regs_pkg.sv
// Shared constants and types for the channel configuration register bank.
// Assumes a single system clock domain and an SPI master on the far side.
package config_regs_pkg;

    // Register width and addresses (7-bit register address field).
    localparam int REG_W = 8;
    localparam logic [6:0] ADDR_REVISION = 7'h00;
    localparam logic [6:0] ADDR_AMP_ONE = 7'h01;
    localparam logic [6:0] ADDR_AMP_TWO = 7'h02;
    localparam logic [6:0] ADDR_MODULATOR = 7'h03;
    localparam logic [6:0] ADDR_BIAS = 7'h04;

    // Reset values of the writable registers.
    localparam logic [7:0] AMP_ONE_RESET = 8'h00;
    localparam logic [7:0] AMP_TWO_RESET = 8'h00;
    localparam logic [7:0] MODULATOR_RESET = 8'h00;
    localparam logic [7:0] BIAS_RESET = 8'h00;

    // Bits that hold a function; all other positions store and read as zero.
    localparam logic [7:0] AMP_ONE_MASK = 8'hFF;
    localparam logic [7:0] AMP_TWO_MASK = 8'hF7;
    localparam logic [7:0] MODULATOR_MASK = 8'hF0;
    localparam logic [7:0] BIAS_MASK = 8'hBF;

    // Input selection codes of the channel one multiplexer.
    localparam logic [1:0] SEL_BOTH = 2'h3;
    localparam logic [1:0] SEL_INPUT_A = 2'h2;
    localparam logic [1:0] SEL_INPUT_B = 2'h1;
    localparam logic [1:0] SEL_TERMINATION = 2'h0;

    // Gain code that holds no gain setting.
    localparam logic [2:0] GAIN_RESERVED = 3'h7;

    // Serial frame layout: command byte then data byte, MSB first.
    localparam int FRAME_BYTE_BITS = 8;
    localparam int READ_FLAG_BIT = 7;
    localparam logic [2:0] LAST_BIT_COUNT = 3'h7;

    // Channel one configuration register, field layout from bit 7 down.
    typedef struct packed {
        logic channel_one_sleep;
        logic channel_one_precision;
        logic [1:0] channel_one_input_select;
        logic guard_off;
        logic [2:0] channel_one_amplification;
    } amp_one_cfg_t;

    // Decoded controls that drive the channel one analog front end.
    typedef struct packed {
        logic sleep;
        logic precision;
        logic input_a_en;
        logic input_b_en;
        logic termination_en;
        logic guard_en;
        logic [2:0] gain_log2;
        logic gain_reserved;
    } channel_one_ctrl_t;

    // Serial frame states.
    typedef enum logic [1:0] {
        FRAME_IDLE = 2'b00,
        FRAME_CMD = 2'b01,
        FRAME_DATA = 2'b10,
        FRAME_DONE = 2'b11
    } frame_state_t;

endpackage

// ===== src/spi_frame_port.sv
// Serial port that turns SPI frames into register read and write requests.
// Assumes SCK runs well below a quarter of the system clock rate.
`timescale 1ns/100ps
module spi_frame_port
    import config_regs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Serial pins.
    input wire logic sck_pin,
    input wire logic cs_n_pin,
    input wire logic mosi_pin,
    output logic miso,
    output logic miso_oe,
    // Register side.
    input wire logic [7:0] read_data,
    output logic [6:0] reg_addr,
    output logic wr_strobe,
    output logic [7:0] wr_data
);

    ////////////////////////////////////////////////////////////////////////////
    logic sck_meta_reg, sck_sync_reg, sck_last_reg;
    logic cs_n_meta_reg, cs_n_sync_reg;
    logic mosi_meta_reg, mosi_sync_reg;
    frame_state_t state_reg, state_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] rx_reg, rx_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] cmd_reg, cmd_next;
    logic load_reg, load_next;
    logic wr_strobe_reg, wr_strobe_next;
    logic [7:0] wr_data_reg, wr_data_next;
    wire sck_rise;
    wire frame_active;
    wire is_read;
    wire [7:0] rx_shifted;

    // Pins pass two flip-flops before any logic looks at them.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_meta_reg <= 1'b0;
            sck_sync_reg <= 1'b0;
            sck_last_reg <= 1'b0;
            cs_n_meta_reg <= 1'b1;
            cs_n_sync_reg <= 1'b1;
            mosi_meta_reg <= 1'b0;
            mosi_sync_reg <= 1'b0;
        end else begin
            sck_meta_reg <= sck_pin;
            sck_sync_reg <= sck_meta_reg;
            sck_last_reg <= sck_sync_reg;
            cs_n_meta_reg <= cs_n_pin;
            cs_n_sync_reg <= cs_n_meta_reg;
            mosi_meta_reg <= mosi_pin;
            mosi_sync_reg <= mosi_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge and frame decode from the synchronised copies only.
    assign frame_active = !cs_n_sync_reg;
    assign sck_rise = frame_active && sck_sync_reg && !sck_last_reg;
    assign is_read = cmd_reg[READ_FLAG_BIT];
    assign rx_shifted = {rx_reg[6:0], mosi_sync_reg};

    // Frame sequencer: command byte, then one data byte, extra bits ignored.
    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        rx_next = rx_reg;
        tx_next = tx_reg;
        cmd_next = cmd_reg;
        load_next = 1'b0;
        wr_strobe_next = 1'b0;
        wr_data_next = wr_data_reg;
        if (load_reg) begin
            tx_next = read_data;
        end
        case (state_reg)
            FRAME_IDLE: begin
                bit_cnt_next = 3'h0;
                if (frame_active) begin
                    state_next = FRAME_CMD;
                end
            end
            FRAME_CMD: begin
                if (sck_rise) begin
                    rx_next = rx_shifted;
                    bit_cnt_next = bit_cnt_reg + 3'h1;
                    if (bit_cnt_reg == LAST_BIT_COUNT) begin
                        cmd_next = rx_shifted;
                        load_next = 1'b1;
                        state_next = FRAME_DATA;
                    end
                end
            end
            FRAME_DATA: begin
                if (sck_rise) begin
                    rx_next = rx_shifted;
                    tx_next = {tx_reg[6:0], 1'b0};
                    bit_cnt_next = bit_cnt_reg + 3'h1;
                    if (bit_cnt_reg == LAST_BIT_COUNT) begin
                        wr_strobe_next = !is_read;
                        wr_data_next = rx_shifted;
                        state_next = FRAME_DONE;
                    end
                end
            end
            FRAME_DONE: begin
                bit_cnt_next = 3'h0;
            end
            default: begin
                state_next = FRAME_IDLE;
            end
        endcase
        // A frame cut short by chip select leaves no effect.
        if (!frame_active) begin
            state_next = FRAME_IDLE;
            wr_strobe_next = 1'b0;
        end
    end

    // Frame state registers.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= FRAME_IDLE;
            bit_cnt_reg <= 3'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            cmd_reg <= 8'h00;
            load_reg <= 1'b0;
            wr_strobe_reg <= 1'b0;
            wr_data_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            cmd_reg <= cmd_next;
            load_reg <= load_next;
            wr_strobe_reg <= wr_strobe_next;
            wr_data_reg <= wr_data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; MISO is driven only during the data byte of a read.
    assign reg_addr = cmd_reg[6:0];
    assign wr_strobe = wr_strobe_reg;
    assign wr_data = wr_data_reg;
    assign miso = tx_reg[7];
    assign miso_oe = (state_reg == FRAME_DATA) && is_read;

endmodule

// ===== testbench/config_regs_assertions.sv
// Port checks for the channel configuration register bank.
// Assumes one clock domain; bound to the top module at the foot of this file.
`timescale 1ns/100ps
module config_regs_assertions
    import config_regs_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // SPI port.
    input wire logic SPI_SCK,
    input wire logic SPI_CS_N,
    input wire logic SPI_MOSI,
    input wire logic SPI_MISO,
    input wire logic SPI_MISO_OE,
    // Configuration outputs.
    input wire channel_one_ctrl_t CH1_CTRL,
    input wire logic [7:0] AMP2_CONFIG,
    input wire logic [7:0] MODULATOR_CONFIG,
    input wire logic [7:0] BIAS_CONFIG
);
    ////////////////////////////////////////////////////////////////////////////////
    // All checks run on the system clock and stop while reset is low.
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    // A long idle gap lets any pending commit land; a short one drains the output enable.
    sequence cs_idle_long;
        SPI_CS_N [*6];
    endsequence
    sequence cs_idle_short;
        SPI_CS_N [*4];
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    reset_zero_a: assert property ($rose(RESETN) |->
        AMP2_CONFIG == 8'h00 && MODULATOR_CONFIG == 8'h00 && BIAS_CONFIG == 8'h00)
        else $error("config outputs not cleared by reset");
    ch1_reset_a: assert property ($rose(RESETN) |=> CH1_CTRL == 10'h030)
        else $error("channel one controls not the decode of zero after reset");
    undef_zero_a: assert property (AMP2_CONFIG[3] == 1'b0 && MODULATOR_CONFIG[3:0] == 4'h0
        && BIAS_CONFIG[6] == 1'b0) else $error("undefined bit reads as one");
    mux_select_a: assert property ($past(RESETN) |-> CH1_CTRL.termination_en ==
        !(CH1_CTRL.input_a_en || CH1_CTRL.input_b_en)) else $error("termination select wrong");
    gain_reserved_a: assert property (CH1_CTRL.gain_reserved |->
        CH1_CTRL.gain_log2 == 3'h0) else $error("reserved gain code drives a gain");
    oe_idle_a: assert property (cs_idle_short |-> !SPI_MISO_OE)
        else $error("output enable high outside a frame");
    cfg_hold_a: assert property (cs_idle_long |-> $stable(CH1_CTRL) && $stable(AMP2_CONFIG)
        && $stable(MODULATOR_CONFIG) && $stable(BIAS_CONFIG))
        else $error("configuration changed with no frame");
    oe_frame_a: assert property ($rose(SPI_MISO_OE) |-> $past(SPI_CS_N, 4) == 1'b0)
        else $error("output enable rose without an open frame");
endmodule

bind seismic_channel_config_regs config_regs_assertions chk_u (.CLK_SYS(CLK_SYS),
    .RESETN(RESETN), .SPI_SCK(SPI_SCK), .SPI_CS_N(SPI_CS_N), .SPI_MOSI(SPI_MOSI),
    .SPI_MISO(SPI_MISO), .SPI_MISO_OE(SPI_MISO_OE), .CH1_CTRL(CH1_CTRL),
    .AMP2_CONFIG(AMP2_CONFIG), .MODULATOR_CONFIG(MODULATOR_CONFIG), .BIAS_CONFIG(BIAS_CONFIG));

// ===== testbench/spi_master_model.sv
// SPI mode 0 master standing in for the external controller.
// Assumes the system clock as its timebase; frames are started by task call.
`timescale 1ns/100ps
module spi_master_model #(
    parameter int HALF = 6
)
(
    // Timebase.
    input wire logic clk,
    // Serial pins.
    output logic sck,
    output logic cs_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle levels: clock low, select high.
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // One frame, MSB first; fewer than 16 rises makes an aborted frame.
    // Read bits taken while the device is not driving come back unknown.
    task automatic xfer(input logic [15:0] word, input int nrise, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk);
        #1 cs_n = 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < nrise; i++) begin
            @(posedge clk);
            #1 mosi = word[15 - i];
            repeat (HALF - 1) @(posedge clk);
            #1 rd = (i >= 8) ? {rd[6:0], (miso_oe ? miso : 1'bx)} : rd;
            sck = 1'b1;
            repeat (HALF) @(posedge clk);
            #1 sck = 1'b0;
        end
        repeat (HALF) @(posedge clk);
        // Half period and gap keep the spacing limits.
        #1 cs_n = 1'b1;
        mosi = ~mosi;
        repeat (6) @(posedge clk);
    endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the channel configuration register bank.
// Assumes the SPI master model drives the serial pins of the design.
`timescale 1ns/100ps
module testbench
    import config_regs_pkg::*;
;
    // Revision code value is arbitrary.
    localparam logic [7:0] REV = 8'h3C;
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } row_t;

    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic sck, cs_n, mosi, miso, miso_oe;
    channel_one_ctrl_t ch1;
    logic [7:0] amp2, modcfg, bias, v;
    int n_fail = 0;
    int checks_done = 0;
    row_t rows [10] = '{'{7'h01, 8'h80, 8'h80}, '{7'h01, 8'h3A, 8'h3A},
        '{7'h01, 8'h25, 8'h25}, '{7'h01, 8'h17, 8'h17}, '{7'h01, 8'h46, 8'h46},
        '{7'h02, 8'hFF, 8'hF7}, '{7'h03, 8'hFF, 8'hF0}, '{7'h04, 8'hFF, 8'hBF},
        '{7'h00, 8'h5A, REV}, '{7'h05, 8'h33, 8'h00}};

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 125 MHz.
    always #4 clk_sys = ~clk_sys;

    seismic_channel_config_regs #(.REVISION_CODE(REV)) dut_u (.CLK_SYS(clk_sys),
        .RESETN(resetn), .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso),
        .SPI_MISO_OE(miso_oe), .CH1_CTRL(ch1), .AMP2_CONFIG(amp2),
        .MODULATOR_CONFIG(modcfg), .BIAS_CONFIG(bias));
    spi_master_model master_u (.clk(clk_sys), .sck(sck), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // Expected channel one controls, worked out from the field layout.
    function automatic channel_one_ctrl_t ch1_exp(input logic [7:0] r);
        channel_one_ctrl_t c;
        c.sleep = r[7];
        c.precision = r[6];
        c.input_a_en = r[5];
        c.input_b_en = r[4];
        c.termination_en = (r[5:4] == 2'h0);
        c.guard_en = ~r[3];
        c.gain_reserved = (r[2:0] == 3'h7);
        c.gain_log2 = c.gain_reserved ? 3'h0 : r[2:0];
        return c;
    endfunction

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Register write and read frames.
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        master_u.xfer({1'b0, a, d}, 16, dummy);
    endtask
    task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
        master_u.xfer({1'b1, a, 8'h00}, 16, d);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the roughly 6000 cycles the tests need.
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_fail++;
        tally_and_finish();
    end

    // Main sequence: reset values, table of writes, then the awkward cases.
    initial begin
        repeat (10) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk_sys);
        check(16'(ch1), 16'(ch1_exp(8'h00)));
        for (int a = 0; a < 5; a++) begin
            rd_reg(7'(a), v);
            check(16'(v), (a == 0) ? 16'(REV) : 16'h0000);
        end
        for (int k = 0; k < 10; k++) begin
            wr_reg(rows[k].addr, rows[k].wdata);
            rd_reg(rows[k].addr, v);
            check(16'(v), 16'(rows[k].rexp));
            case (rows[k].addr)
                7'h01: check(16'(ch1), 16'(ch1_exp(rows[k].rexp)));
                7'h02: check(16'(amp2), 16'(rows[k].rexp));
                7'h03: check(16'(modcfg), 16'(rows[k].rexp));
                7'h04: check(16'(bias), 16'(rows[k].rexp));
                default: check(16'(bias), 16'h00BF);
            endcase
        end
        // A frame cut short after 12 rises must not write.
        master_u.xfer({1'b0, 7'h01, 8'hC1}, 12, v);
        rd_reg(7'h01, v);
        check(16'(v), 16'h0046);
        // Reset in mid-run clears the writable registers only.
        #1 resetn = 1'b0;
        @(posedge clk_sys);
        #1 check({ch1, amp2[5:0]}, 16'h0000);
        check({modcfg, bias}, 16'h0000);
        repeat (3) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_reg(7'h00, v);
        check(16'(v), 16'(REV));
        rd_reg(7'h01, v);
        check(16'(v), 16'h0000);
        tally_and_finish();
    end
endmodule
